// *** logic/ddrcad_pkg.sv ***
// constants and types for the command/address pin decode
// assumes a single clock domain on the design side
`default_nettype none
package ddrcad_pkg;
   localparam int ADDR_W = 18;
   localparam int COL_W = 10;
   localparam int BANK_W = 2;
   localparam int BG_W = 2;
   localparam int MR_W = 4;
   localparam int FLAT_W = 4;
   localparam int ID_W = 3;
   // bit positions in the synchronised pin vector
   localparam int POS_ADDR = 0;
   localparam int POS_BA = 18;
   localparam int POS_BG = 20;
   localparam int POS_ID = 22;
   localparam int POS_WE = 25;
   localparam int POS_CAS = 26;
   localparam int POS_RAS = 27;
   localparam int POS_ACT = 28;
   localparam int POS_CS = 29;
   localparam int POS_CKT = 30;
   localparam int POS_CKC = 31;
   localparam int POS_X16 = 32;
   localparam int POS_STK = 33;
   localparam int PIN_W = 34;
   // address bits with a second job
   localparam int AP_BIT = 10;
   localparam int BC_BIT = 12;
   // strobe codes {row, column, write}, active low
   localparam logic [2:0] CODE_MRS = 3'h0;
   localparam logic [2:0] CODE_REF = 3'h1;
   localparam logic [2:0] CODE_PRE = 3'h2;
   localparam logic [2:0] CODE_WR = 3'h4;
   localparam logic [2:0] CODE_RD = 3'h5;
   // reset values
   localparam logic [ADDR_W-1:0] ADDR_RST = 18'h00000;
   localparam logic [ID_W-1:0] ID_RST = 3'h0;
   typedef enum logic [2:0] {
      KIND_NONE, KIND_ACT, KIND_RD, KIND_WR, KIND_PRE, KIND_MRS,
      KIND_REF, KIND_OTHER
   } ddrcad_kind_t;
endpackage : ddrcad_pkg
`default_nettype wire

// *** logic/ddrcad_sync.sv ***
// two-flop synchroniser for a vector of independent levels
// assumes inputs come from outside the clock domain
`default_nettype none
module ddrcad_sync #(
   parameter int W = 1
) (
   input wire logic clock_i,
   input wire logic rst_b_i,
   input wire logic [W-1:0] async_i,
   output logic [W-1:0] sync_o
);
   genvar g;
   generate
      for (g = 0; g < W; g++) begin : g_bit
         logic meta_q;
         logic stab_q;
         always_ff @(posedge clock_i or negedge rst_b_i) begin
            if (!rst_b_i) begin
               meta_q <= 1'b0;
               stab_q <= 1'b0;
            end else begin
               meta_q <= async_i[g];
               stab_q <= meta_q;
            end
         end
         assign sync_o[g] = stab_q;
      end
   endgenerate
endmodule : ddrcad_sync
`default_nettype wire

// *** logic/ddrcad_decode.sv ***
// command and address pin decode of the memory device
// assumes link pins arrive asynchronous to clock_i, clock pair period 300 ns
`default_nettype none
module ddrcad_decode (
   input wire logic clock_i,
   input wire logic rst_b_i,
   input wire logic clock_true_i,
   input wire logic clock_complement_i,
   input wire logic chip_select_low_i,
   input wire logic activate_strobe_low_i,
   input wire logic row_strobe_or_addr16_i,
   input wire logic column_strobe_or_addr15_i,
   input wire logic write_strobe_or_addr14_i,
   input wire logic [17:0] addr_i,
   input wire logic [1:0] bank_select_i,
   input wire logic [1:0] bank_group_select_i,
   input wire logic stack_id_bit0_i,
   input wire logic stack_id_bit1_i,
   input wire logic stack_id_bit2_i,
   input wire logic config_x16_i,
   input wire logic stack_enable_i,
   output logic cmd_valid_o,
   output ddrcad_pkg::ddrcad_kind_t cmd_kind_o,
   output logic [17:0] row_addr_o,
   output logic [9:0] col_addr_o,
   output logic [17:0] opcode_o,
   output logic [3:0] mode_reg_o,
   output logic [1:0] bank_o,
   output logic [1:0] bank_group_o,
   output logic [3:0] flat_bank_o,
   output logic auto_precharge_o,
   output logic precharge_all_o,
   output logic burst_chopped_o,
   output logic [2:0] chip_id_o
);
   function automatic ddrcad_pkg::ddrcad_kind_t kind_of(
      input logic activate_strobe_low, input logic [2:0] code);
      ddrcad_pkg::ddrcad_kind_t k;
      k = ddrcad_pkg::KIND_OTHER;
      if (!activate_strobe_low) begin
         k = ddrcad_pkg::KIND_ACT;
      end else begin
         case (code)
            ddrcad_pkg::CODE_MRS: k = ddrcad_pkg::KIND_MRS;
            ddrcad_pkg::CODE_REF: k = ddrcad_pkg::KIND_REF;
            ddrcad_pkg::CODE_PRE: k = ddrcad_pkg::KIND_PRE;
            ddrcad_pkg::CODE_WR: k = ddrcad_pkg::KIND_WR;
            ddrcad_pkg::CODE_RD: k = ddrcad_pkg::KIND_RD;
            default: k = ddrcad_pkg::KIND_OTHER;
         endcase
      end
      return k;
   endfunction : kind_of

   logic [ddrcad_pkg::PIN_W-1:0] pins;
   logic [ddrcad_pkg::PIN_W-1:0] s;
   assign pins = {stack_enable_i, config_x16_i, clock_complement_i,
      clock_true_i, chip_select_low_i, activate_strobe_low_i,
      row_strobe_or_addr16_i, column_strobe_or_addr15_i,
      write_strobe_or_addr14_i,
      {stack_id_bit2_i, stack_id_bit1_i, stack_id_bit0_i},
      bank_group_select_i, bank_select_i, addr_i};

   ddrcad_sync #(.W(ddrcad_pkg::PIN_W)) u_sync (
      .clock_i(clock_i),
      .rst_b_i(rst_b_i),
      .async_i(pins),
      .sync_o(s)
   );

   logic [17:0] a;
   logic [2:0] code;
   logic [1:0] bg_eff;
   logic [1:0] ba;
   logic ck_hi;
   logic edge_sel;
   assign a = s[ddrcad_pkg::POS_ADDR +: ddrcad_pkg::ADDR_W];
   assign code = {s[ddrcad_pkg::POS_RAS], s[ddrcad_pkg::POS_CAS],
      s[ddrcad_pkg::POS_WE]};
   assign ba = s[ddrcad_pkg::POS_BA +: ddrcad_pkg::BANK_W];
   // x16 has no upper group bit
   assign bg_eff = {s[ddrcad_pkg::POS_BG + 1] & ~s[ddrcad_pkg::POS_X16],
      s[ddrcad_pkg::POS_BG]};
   assign ck_hi = s[ddrcad_pkg::POS_CKT] & ~s[ddrcad_pkg::POS_CKC];
   logic ck_hi_q;
   // crossing of true rising and complement falling
   assign edge_sel = ck_hi & ~ck_hi_q & ~s[ddrcad_pkg::POS_CS];

   logic valid_d, valid_q;
   ddrcad_pkg::ddrcad_kind_t kind_d, kind_q;
   logic [17:0] row_d, row_q, op_d, op_q;
   logic [9:0] col_d, col_q;
   logic [3:0] mr_d, mr_q, flat_d, flat_q;
   logic [1:0] ba_d, ba_q, bg_d, bg_q;
   logic ap_d, ap_q, pall_d, pall_q, bc_d, bc_q;
   logic [2:0] id_d, id_q;

   always_comb begin
      ddrcad_pkg::ddrcad_kind_t k;
      k = kind_of(s[ddrcad_pkg::POS_ACT], code);
      valid_d = 1'b0;
      kind_d = kind_q;
      row_d = row_q;
      col_d = col_q;
      op_d = op_q;
      mr_d = mr_q;
      ba_d = ba_q;
      bg_d = bg_q;
      flat_d = flat_q;
      ap_d = ap_q;
      pall_d = pall_q;
      bc_d = bc_q;
      id_d = id_q;
      if (edge_sel) begin
         valid_d = 1'b1;
         kind_d = k;
         // stack ids only on stacked x8 parts
         id_d = (s[ddrcad_pkg::POS_STK] && !s[ddrcad_pkg::POS_X16]) ?
            s[ddrcad_pkg::POS_ID +: ddrcad_pkg::ID_W] :
            ddrcad_pkg::ID_RST;
         if (k == ddrcad_pkg::KIND_ACT) begin
            row_d = {a[17], code, a[13:0]};
         end
         if (k == ddrcad_pkg::KIND_RD || k == ddrcad_pkg::KIND_WR) begin
            col_d = a[ddrcad_pkg::COL_W-1:0];
            ap_d = a[ddrcad_pkg::AP_BIT];
            bc_d = ~a[ddrcad_pkg::BC_BIT];
         end
         if (k == ddrcad_pkg::KIND_PRE) begin
            pall_d = a[ddrcad_pkg::AP_BIT];
         end
         if (k == ddrcad_pkg::KIND_ACT || k == ddrcad_pkg::KIND_RD ||
             k == ddrcad_pkg::KIND_WR || k == ddrcad_pkg::KIND_PRE) begin
            ba_d = ba;
            bg_d = bg_eff;
            flat_d = {bg_eff, ba};
         end
         if (k == ddrcad_pkg::KIND_MRS) begin
            op_d = a;
            mr_d = {bg_eff, ba};
         end
      end
   end

   always_ff @(posedge clock_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         ck_hi_q <= 1'b0;
         valid_q <= 1'b0;
         kind_q <= ddrcad_pkg::KIND_NONE;
         row_q <= ddrcad_pkg::ADDR_RST;
         col_q <= 10'h000;
         op_q <= ddrcad_pkg::ADDR_RST;
         mr_q <= 4'h0;
         ba_q <= 2'h0;
         bg_q <= 2'h0;
         flat_q <= 4'h0;
         ap_q <= 1'b0;
         pall_q <= 1'b0;
         bc_q <= 1'b0;
         id_q <= ddrcad_pkg::ID_RST;
      end else begin
         ck_hi_q <= ck_hi;
         valid_q <= valid_d;
         kind_q <= kind_d;
         row_q <= row_d;
         col_q <= col_d;
         op_q <= op_d;
         mr_q <= mr_d;
         ba_q <= ba_d;
         bg_q <= bg_d;
         flat_q <= flat_d;
         ap_q <= ap_d;
         pall_q <= pall_d;
         bc_q <= bc_d;
         id_q <= id_d;
      end
   end

   assign cmd_valid_o = valid_q;
   assign cmd_kind_o = kind_q;
   assign row_addr_o = row_q;
   assign col_addr_o = col_q;
   assign opcode_o = op_q;
   assign mode_reg_o = mr_q;
   assign bank_o = ba_q;
   assign bank_group_o = bg_q;
   assign flat_bank_o = flat_q;
   assign auto_precharge_o = ap_q;
   assign precharge_all_o = pall_q;
   assign burst_chopped_o = bc_q;
   assign chip_id_o = id_q;

   // checks
   logic rise_any;
   assign rise_any = ck_hi & ~ck_hi_q;
   sequence seq_take;
      rise_any ##0 !s[ddrcad_pkg::POS_CS];
   endsequence
   sequence seq_act;
      seq_take ##0 !s[ddrcad_pkg::POS_ACT];
   endsequence
   sequence seq_rdwr;
      seq_take ##0 s[ddrcad_pkg::POS_ACT] ##0
         (code == ddrcad_pkg::CODE_RD || code == ddrcad_pkg::CODE_WR);
   endsequence

   chk_take_pulse: assert property (
      @(posedge clock_i) disable iff (!rst_b_i)
      seq_take |=> cmd_valid_o ##1 !cmd_valid_o)
      else $error("accepted crossing gave no single pulse");
   chk_cs_mask: assert property (
      @(posedge clock_i) disable iff (!rst_b_i)
      rise_any && s[ddrcad_pkg::POS_CS] |=> !cmd_valid_o)
      else $error("command taken while chip select high");
   chk_act_row: assert property (
      @(posedge clock_i) disable iff (!rst_b_i)
      seq_act |=> cmd_kind_o == ddrcad_pkg::KIND_ACT &&
         row_addr_o[16:14] == $past(code) &&
         row_addr_o[13:0] == $past(a[13:0]))
      else $error("activate row bits wrong");
   chk_cmd_decode: assert property (
      @(posedge clock_i) disable iff (!rst_b_i)
      seq_take ##0 s[ddrcad_pkg::POS_ACT] |=>
         cmd_kind_o == kind_of(1'b1, $past(code)))
      else $error("strobe command decoded wrong");
   chk_col_addr: assert property (
      @(posedge clock_i) disable iff (!rst_b_i)
      seq_rdwr |=> col_addr_o == $past(a[9:0]))
      else $error("column address wrong");
   chk_mrs_opcode: assert property (
      @(posedge clock_i) disable iff (!rst_b_i)
      seq_take ##0 s[ddrcad_pkg::POS_ACT] ##0
         code == ddrcad_pkg::CODE_MRS |=>
         opcode_o == $past(a) && mode_reg_o == $past({bg_eff, ba}))
      else $error("mode register set capture wrong");
   chk_auto_pre: assert property (
      @(posedge clock_i) disable iff (!rst_b_i)
      seq_rdwr |=> auto_precharge_o == $past(a[10]) &&
         burst_chopped_o == !$past(a[12]))
      else $error("auto precharge or burst chop wrong");
   chk_pre_all: assert property (
      @(posedge clock_i) disable iff (!rst_b_i)
      seq_take ##0 s[ddrcad_pkg::POS_ACT] ##0
         code == ddrcad_pkg::CODE_PRE |=>
         precharge_all_o == $past(a[10]) &&
         flat_bank_o == $past({bg_eff, ba}))
      else $error("precharge scope wrong");
   chk_bank_sel: assert property (
      @(posedge clock_i) disable iff (!rst_b_i)
      seq_act |=> bank_o == $past(ba) &&
         flat_bank_o == $past({bg_eff, ba}))
      else $error("bank select wrong");
   chk_x16_group: assert property (
      @(posedge clock_i) disable iff (!rst_b_i)
      seq_take ##0 s[ddrcad_pkg::POS_X16] |=>
         ((cmd_kind_o != ddrcad_pkg::KIND_MRS || !mode_reg_o[3]) &&
         (cmd_kind_o == ddrcad_pkg::KIND_MRS ||
         cmd_kind_o == ddrcad_pkg::KIND_REF ||
         cmd_kind_o == ddrcad_pkg::KIND_OTHER || !bank_group_o[1])))
      else $error("x16 used upper bank group bit");
   chk_chip_id: assert property (
      @(posedge clock_i) disable iff (!rst_b_i)
      seq_take ##0 (s[ddrcad_pkg::POS_X16] ||
         !s[ddrcad_pkg::POS_STK]) |=> chip_id_o == 3'h0)
      else $error("chip id set on unstacked part");
endmodule : ddrcad_decode
`default_nettype wire

// *** verification/ddrcad_ctl_model.sv ***
// controller model driving the command and address pins
// assumes clock_i is the device clock; link clock made here, idle low
`default_nettype none
module ddrcad_ctl_model (
   input wire logic clock_i,
   output logic ckt_o,
   output logic ckc_o,
   output logic gate_o,
   output logic csl_o,
   output logic actl_o,
   output logic [2:0] strb_o,
   output logic [17:0] addr_o,
   output logic [1:0] ba_o,
   output logic [1:0] bg_o,
   output logic [2:0] id_o
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      {ckt_o, ckc_o, csl_o, actl_o} = 4'h7;
      gate_o = 1'b1;
      {strb_o, addr_o, ba_o, bg_o, id_o} = '0;
   end
   // one command per link period, clock still between frames
   task automatic issue(input logic cs, input logic act,
         input logic [2:0] s, input logic [17:0] a,
         input logic [1:0] b, input logic [1:0] g, input logic [2:0] id);
      @(posedge clock_i);
      {csl_o, actl_o, strb_o, addr_o} <= {cs, act, s, a};
      {ba_o, bg_o, id_o} <= {b, g, id};
      repeat (3) @(posedge clock_i);
      ckt_o <= 1'b1;
      ckc_o <= 1'b0;
      repeat (4) @(posedge clock_i);
      ckt_o <= 1'b0;
      ckc_o <= 1'b1;
      // hold over: lines show the inverse
      {csl_o, actl_o, strb_o, addr_o} <= ~{cs, act, s, a};
      {ba_o, bg_o, id_o} <= ~{b, g, id};
      repeat (4) @(posedge clock_i);
   endtask : issue
endmodule : ddrcad_ctl_model
`default_nettype wire

// *** verification/ddrcad_decode_tb_top.sv ***
// bench for the command and address pin decode
// assumes the controller model drives all link pins
`default_nettype none
module ddrcad_decode_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic clock_i = 1'b0;
   logic rst_b_i = 1'b0;
   logic x16 = 1'b0;
   logic stk = 1'b0;
   logic ckt, ckc, gate, csl, actl, vld, ap, pall, chop;
   logic [2:0] strb, id, cid;
   logic [17:0] addr, row, opc;
   logic [1:0] ba, bg, bko, bgo;
   logic [9:0] col;
   logic [3:0] mreg, flat;
   ddrcad_pkg::ddrcad_kind_t kind, kseen;
   int miscompares = 0;
   int n_checks = 0;
   int n_pulses = 0;
   always #12.5 clock_i = ~clock_i;
   ddrcad_ctl_model ctl (.clock_i(clock_i), .ckt_o(ckt), .ckc_o(ckc),
      .gate_o(gate),
      .csl_o(csl), .actl_o(actl), .strb_o(strb), .addr_o(addr),
      .ba_o(ba), .bg_o(bg), .id_o(id));
   ddrcad_decode uut (.clock_i(clock_i), .rst_b_i(rst_b_i),
      .clock_true_i(ckt), .clock_complement_i(ckc),
      .chip_select_low_i(csl), .activate_strobe_low_i(actl),
      .row_strobe_or_addr16_i(strb[2]),
      .column_strobe_or_addr15_i(strb[1]),
      .write_strobe_or_addr14_i(strb[0]), .addr_i(addr),
      .bank_select_i(ba), .bank_group_select_i(bg),
      .stack_id_bit0_i(id[0]), .stack_id_bit1_i(id[1]),
      .stack_id_bit2_i(id[2]), .config_x16_i(x16),
      .stack_enable_i(stk), .cmd_valid_o(vld), .cmd_kind_o(kind),
      .row_addr_o(row), .col_addr_o(col), .opcode_o(opc),
      .mode_reg_o(mreg), .bank_o(bko), .bank_group_o(bgo),
      .flat_bank_o(flat), .auto_precharge_o(ap),
      .precharge_all_o(pall), .burst_chopped_o(chop), .chip_id_o(cid));
   always @(posedge clock_i) begin
      if (vld === 1'b1) begin
         n_pulses++;
         kseen = kind;
      end
   end
   task automatic results();
      if (miscompares == 0 && n_checks > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : results
   task automatic chk(input logic [17:0] seen, input logic [17:0] exp);
      n_checks++;
      if (seen !== exp) begin
         miscompares++;
         $display("[FAIL] %0t ns: saw %h want %h", $time, seen, exp);
      end
   endtask : chk
   task automatic cmd(input logic cs, input logic act,
         input logic [2:0] s, input logic [17:0] a,
         input logic [1:0] b, input logic [1:0] g, input logic [2:0] i,
         input ddrcad_pkg::ddrcad_kind_t k);
      int n0;
      n0 = n_pulses;
      ctl.issue(cs, act, s, a, b, g, i);
      chk(18'(n_pulses - n0), 18'(cs === 1'b0));
      if (cs === 1'b0) chk(18'(kseen), 18'(k));
   endtask : cmd
   task automatic t_reset();
      chk(18'(vld), 18'h0);
      chk(18'(kind), 18'(ddrcad_pkg::KIND_NONE));
      chk(row, 18'h0);
   endtask : t_reset
   task automatic t_act();
      cmd(1'b0, 1'b0, 3'h5, 18'h2aa5c, 2'h2, 2'h3, 3'h0,
          ddrcad_pkg::KIND_ACT);
      chk(row, 18'h36a5c);
      chk(18'({bgo, bko}), 18'h00e);
      chk(18'(flat), 18'h00e);
   endtask : t_act
   task automatic t_rdwr();
      for (int i = 0; i < 2; i++) begin
         cmd(1'b0, 1'b1, i ? ddrcad_pkg::CODE_WR : ddrcad_pkg::CODE_RD,
             i ? 18'h012b3 : 18'h005a5, 2'(i), 2'(3 - i), 3'h0,
             i ? ddrcad_pkg::KIND_WR : ddrcad_pkg::KIND_RD);
         chk(18'(col), i ? 18'h002b3 : 18'h001a5);
         chk(18'(ap), 18'(1 - i));
         chk(18'(chop), 18'(1 - i));
         chk(18'(flat), 18'((3 - i) * 4 + i));
         chk(18'(gate), 18'h1);
      end
   endtask : t_rdwr
   task automatic t_pre();
      for (int i = 0; i < 2; i++) begin
         cmd(1'b0, 1'b1, ddrcad_pkg::CODE_PRE, 18'(i) << 10, 2'h1, 2'h2,
             3'h0, ddrcad_pkg::KIND_PRE);
         chk(18'(pall), 18'(i));
         chk(18'(flat), 18'h00009);
      end
   endtask : t_pre
   task automatic t_mrs();
      cmd(1'b0, 1'b1, ddrcad_pkg::CODE_MRS, 18'h3c0f1, 2'h1, 2'h2, 3'h0,
          ddrcad_pkg::KIND_MRS);
      chk(opc, 18'h3c0f1);
      chk(18'(mreg), 18'h00009);
      cmd(1'b0, 1'b1, ddrcad_pkg::CODE_REF, 18'h00000, 2'h0, 2'h0, 3'h0,
          ddrcad_pkg::KIND_REF);
      cmd(1'b0, 1'b1, 3'h7, 18'h00000, 2'h0, 2'h0, 3'h0,
          ddrcad_pkg::KIND_OTHER);
   endtask : t_mrs
   task automatic t_cs_high();
      cmd(1'b1, 1'b1, ddrcad_pkg::CODE_RD, 18'h00400, 2'h0, 2'h0, 3'h0,
          ddrcad_pkg::KIND_RD);
      chk(18'(col), 18'h002b3);
      chk(18'(ap), 18'h0);
   endtask : t_cs_high
   task automatic t_x16();
      x16 <= 1'b1;
      cmd(1'b0, 1'b0, 3'h0, 18'h00000, 2'h1, 2'h3, 3'h0,
          ddrcad_pkg::KIND_ACT);
      chk(18'(bgo), 18'h1);
      chk(18'(flat), 18'h5);
      cmd(1'b0, 1'b1, ddrcad_pkg::CODE_MRS, 18'h00000, 2'h2, 2'h3, 3'h0,
          ddrcad_pkg::KIND_MRS);
      chk(18'(mreg), 18'h6);
   endtask : t_x16
   task automatic t_stack();
      for (int i = 0; i < 3; i++) begin
         @(posedge clock_i);
         stk <= (i < 2);
         x16 <= (i == 1);
         cmd(1'b0, 1'b0, 3'h0, 18'h00000, 2'h0, 2'h0, 3'h5,
             ddrcad_pkg::KIND_ACT);
         chk(18'(cid), i ? 18'h0 : 18'h5);
      end
   endtask : t_stack
   initial begin
      repeat (16) @(posedge clock_i);
      rst_b_i <= 1'b1;
      repeat (4) @(posedge clock_i);
      t_reset();
      t_act();
      t_rdwr();
      t_pre();
      t_mrs();
      t_cs_high();
      t_x16();
      t_stack();
      results();
   end
   initial begin
      repeat (4000) @(posedge clock_i);
      miscompares++;
      results();
   end
endmodule : ddrcad_decode_tb_top
`default_nettype wire
